//--- hw/brms_bus_ctrl.sv
`timescale 1ns/10ps
module brms_bus_ctrl
    import brms_pkg::*;
#(
    parameter int unsigned AW = brms_pkg::ADDR_W,
    parameter int unsigned DW = brms_pkg::DATA_W
) (
    input  wire logic                          clk,
    input  wire logic                          sys_rst,
    input  wire logic                          req_valid,
    input  wire logic                          req_write,
    input  wire logic [AW-1:0]                 req_addr,
    input  wire logic [DW-1:0]                 req_wdata,
    output logic                               req_ready,
    output logic                               rsp_valid,
    output logic [DW-1:0]                      rsp_rdata,
    input  wire logic                          sync_ready,
    input  wire logic                          async_ready,
    input  wire logic                          bus_hold_req,
    output logic                               bus_grant_ack,
    output logic                               processor_clock_out,
    output logic [DW-1:0]                      muxed_addr_data_o,
    output logic                               muxed_addr_data_oe_n,
    input  wire logic [DW-1:0]                 muxed_addr_data_i,
    output logic [AW-DW-1:0]                   upper_address_o,
    output logic                               upper_address_oe_n,
    output logic                               byte_high_enable_n_o,
    output logic                               byte_high_enable_n_oe_n,
    output logic [brms_pkg::STATUS_W-1:0]      bus_cycle_status_o,
    output logic                               bus_cycle_status_oe_n,
    output logic                               read_strobe_n_o,
    output logic                               write_strobe_n_o,
    output logic                               transceiver_enable_n_o,
    output logic                               strobes_oe_n,
    output logic                               transceiver_direction_o,
    output logic                               transceiver_direction_oe_n,
    output logic                               bus_lock_o,
    output logic                               bus_lock_oe_n,
    output logic                               addr_latch_strobe,
    input  wire logic                          read_or_queue_strap,
    input  wire logic                          upper_mem_select,
    input  wire logic                          lower_mem_select,
    input  wire logic                          test_busy,
    output logic                               strap_pullup_en,
    output logic                               queue_status_mode,
    output logic                               pin_float_test_mode,
    output logic                               extended_mode,
    output logic                               power_save_en,
    output logic                               refresh_en,
    output logic                               coproc_if_en
);
    import brms_pkg::*;

    brms_clk_if ck ();
    brms_clk_div u_div (
        .clk     (clk),
        .sys_rst (sys_rst),
        .ck      (ck)
    );

    brms_rst_state_t rst_r;
    brms_bus_state_t bus_r;
    brms_bus_state_t bus_nxt;
    logic            rst_seen_r;
    logic            clk_out_r;
    logic            qs_strap_r;
    logic            uls_strap_r;
    logic            test_low_r;
    logic            qsm_r;
    logic            float_test_r;
    logic            ext_r;
    logic            write_r;
    logic [AW-1:0]   addr_r;
    logic [DW-1:0]   wdata_r;
    logic [DW-1:0]   rdata_r;
    logic            rsp_r;
    logic            ack_r;
    logic            drive_r;

    wire running  = (rst_r == BRMS_RUN);
    wire tick     = ck.tick & running;
    wire ready_in = sync_ready | async_ready;
    wire in_cycle = (bus_r == BRMS_T1) || (bus_r == BRMS_T2) || (bus_r == BRMS_T3)
                    || (bus_r == BRMS_TW) || (bus_r == BRMS_T4);
    wire data_ph  = (bus_r == BRMS_T2) || (bus_r == BRMS_T3) || (bus_r == BRMS_TW);
    wire end_wait = (bus_r == BRMS_T3 || bus_r == BRMS_TW) && ready_in;
    wire float_n  = ~drive_r | ~running | float_test_r;
    wire qs_busy  = in_cycle;

    // bus cycle sequencing: T1..T4, waits while ready low
    always_comb begin
        bus_nxt = bus_r;
        case (bus_r)
            BRMS_T_IDLE: begin
                if (bus_hold_req) begin
                    bus_nxt = BRMS_HOLD;
                end else if (req_valid) begin
                    bus_nxt = BRMS_T1;
                end
            end
            BRMS_T1: bus_nxt = BRMS_T2;
            BRMS_T2: bus_nxt = BRMS_T3;
            BRMS_T3: bus_nxt = ready_in ? BRMS_T4 : BRMS_TW;
            BRMS_TW: bus_nxt = ready_in ? BRMS_T4 : BRMS_TW;
            BRMS_T4: bus_nxt = BRMS_T_IDLE;
            BRMS_HOLD: bus_nxt = bus_hold_req ? BRMS_HOLD : BRMS_T_IDLE;
            default: bus_nxt = BRMS_T_IDLE;
        endcase
    end

    // reset sequence on the divided clock
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rst_r      <= BRMS_RST_DRIVE;
            rst_seen_r <= 1'b0;
        end else if (ck.tick) begin
            rst_seen_r <= 1'b1;
            case (rst_r)
                BRMS_RST_DRIVE: rst_r <= BRMS_RST_FLOAT;
                BRMS_RST_FLOAT: rst_r <= BRMS_RUN;
                BRMS_RUN: rst_r <= BRMS_RUN;
                default: rst_r <= BRMS_RUN;
            endcase
        end
    end

    // strap sampling during reset, fixed after release
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            qs_strap_r   <= read_or_queue_strap;
            uls_strap_r  <= ~upper_mem_select & ~lower_mem_select;
            qsm_r        <= 1'b0;
            float_test_r <= 1'b0;
            ext_r        <= 1'b0;
            // first reset cycle starts a fresh low-seen record
            if (rst_r == BRMS_RST_DRIVE) begin
                test_low_r <= test_low_r | ~test_busy;
            end else begin
                test_low_r <= ~test_busy;
            end
        end else if (!running && rst_seen_r && ck.tick) begin
            qsm_r        <= ~qs_strap_r;
            float_test_r <= uls_strap_r;
            ext_r        <= test_low_r & test_busy;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            clk_out_r <= 1'b0;
        end else begin
            clk_out_r <= ck.phase;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            bus_r   <= BRMS_T_IDLE;
            write_r <= 1'b0;
            addr_r  <= '0;
            wdata_r <= '0;
            rdata_r <= '0;
            rsp_r   <= 1'b0;
            ack_r   <= 1'b0;
            drive_r <= 1'b1;
        end else begin
            rsp_r <= 1'b0;
            if (tick) begin
                bus_r   <= bus_nxt;
                ack_r   <= (bus_nxt == BRMS_HOLD);
                drive_r <= (bus_nxt != BRMS_HOLD);
                if (bus_r == BRMS_T_IDLE && bus_nxt == BRMS_T1) begin
                    write_r <= req_write;
                    addr_r  <= req_addr;
                    wdata_r <= req_wdata;
                end
                if (end_wait && !write_r) begin
                    rdata_r <= muxed_addr_data_i;
                end
                rsp_r <= (bus_r == BRMS_T4);
            end
        end
    end

    // pins
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            muxed_addr_data_o       <= '0;
            muxed_addr_data_oe_n    <= 1'b1;
            upper_address_o         <= '0;
            upper_address_oe_n      <= 1'b1;
            byte_high_enable_n_o    <= 1'b1;
            byte_high_enable_n_oe_n <= 1'b1;
            transceiver_direction_o <= 1'b0;
            transceiver_direction_oe_n <= 1'b1;
            read_strobe_n_o         <= 1'b1;
            write_strobe_n_o        <= 1'b1;
            transceiver_enable_n_o  <= 1'b1;
            strobes_oe_n            <= 1'b0;
            bus_cycle_status_o      <= STATUS_IDLE;
            bus_cycle_status_oe_n   <= 1'b0;
            bus_lock_o              <= 1'b1;
            bus_lock_oe_n           <= 1'b0;
            addr_latch_strobe       <= 1'b0;
            bus_grant_ack           <= 1'b0;
            strap_pullup_en         <= 1'b1;
        end else begin
            strap_pullup_en <= ~running;
            bus_grant_ack   <= ack_r & running;
            strobes_oe_n    <= (rst_r != BRMS_RST_DRIVE) & float_n;
            bus_cycle_status_oe_n <= (rst_r != BRMS_RST_DRIVE) & float_n;
            bus_lock_oe_n   <= (rst_r != BRMS_RST_DRIVE) & float_n;
            bus_lock_o      <= 1'b1;
            muxed_addr_data_oe_n <= float_n | ~(bus_r == BRMS_T1 || (write_r && data_ph));
            muxed_addr_data_o <= (bus_r == BRMS_T1) ? addr_r[DW-1:0] : wdata_r;
            upper_address_oe_n <= float_n;
            upper_address_o    <= addr_r[AW-1:DW];
            byte_high_enable_n_oe_n <= float_n;
            byte_high_enable_n_o    <= ~in_cycle;
            transceiver_direction_oe_n <= float_n;
            transceiver_direction_o <= ~in_cycle | write_r;
            transceiver_enable_n_o  <= ~data_ph;
            bus_cycle_status_o <= !in_cycle ? STATUS_IDLE
                                : (write_r ? STATUS_WRITE : STATUS_READ);
            if (qsm_r) begin
                addr_latch_strobe <= qs_busy;
                write_strobe_n_o  <= data_ph;
            end else begin
                addr_latch_strobe <= (bus_r == BRMS_T1) & running;
                write_strobe_n_o  <= ~(data_ph & write_r);
            end
            read_strobe_n_o <= ~(data_ph & ~write_r);
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            processor_clock_out <= 1'b0;
            req_ready           <= 1'b0;
            rsp_valid           <= 1'b0;
            rsp_rdata           <= '0;
            queue_status_mode   <= 1'b0;
            pin_float_test_mode <= 1'b0;
            extended_mode       <= 1'b0;
            power_save_en       <= 1'b0;
            refresh_en          <= 1'b0;
            coproc_if_en        <= 1'b0;
        end else begin
            processor_clock_out <= clk_out_r;
            req_ready           <= tick & (bus_r == BRMS_T_IDLE) & ~bus_hold_req;
            rsp_valid           <= rsp_r;
            rsp_rdata           <= rdata_r;
            queue_status_mode   <= qsm_r & running;
            pin_float_test_mode <= float_test_r & running;
            extended_mode       <= ext_r & running;
            power_save_en       <= ext_r & running;
            refresh_en          <= ext_r & running;
            coproc_if_en        <= ext_r & running;
        end
    end
endmodule

//--- hw/brms_pkg.sv
package brms_pkg;
    localparam int unsigned CLK_HZ          = 10000000;
    localparam int unsigned ADDR_W          = 20;
    localparam int unsigned DATA_W          = 16;
    localparam int unsigned UPPER_W         = 4;
    localparam int unsigned STATUS_W        = 3;
    localparam int unsigned MIN_BUS_STATES  = 4;
    localparam int unsigned RST_DRIVE_TICKS = 1;
    localparam logic [2:0]  STATUS_IDLE     = 3'h7;
    localparam logic [2:0]  STATUS_READ     = 3'h5;
    localparam logic [2:0]  STATUS_WRITE    = 3'h6;
    typedef enum logic [1:0] {
        BRMS_RST_DRIVE,
        BRMS_RST_FLOAT,
        BRMS_RUN
    } brms_rst_state_t;
    typedef enum logic [2:0] {
        BRMS_T_IDLE,
        BRMS_T1,
        BRMS_T2,
        BRMS_T3,
        BRMS_TW,
        BRMS_T4,
        BRMS_HOLD
    } brms_bus_state_t;
endpackage

//--- hw/brms_clk_if.sv
`timescale 1ns/10ps
interface brms_clk_if;
    logic tick;
    logic phase;
    modport src (output tick, output phase);
    modport dst (input tick, input phase);
endinterface

//--- hw/brms_clk_div.sv
`timescale 1ns/10ps
module brms_clk_div (
    input  wire logic clk,
    input  wire logic sys_rst,
    brms_clk_if.src   ck
);
    logic phase_r;
    // divide by two: phase toggles each clk, tick on every second edge
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            phase_r <= 1'b0;
        end else begin
            phase_r <= ~phase_r;
        end
    end
    assign ck.phase = phase_r;
    assign ck.tick  = phase_r;
endmodule

//--- testbench/brms_mem_model.sv
`timescale 1ns/10ps
module brms_mem_model (
    input  wire logic        clk,
    input  wire logic [15:0] ad_o,
    input  wire logic        ad_oe_n,
    input  wire logic [3:0]  up_o,
    input  wire logic        ale,
    input  wire logic        rd_n,
    input  wire logic        wr_n,
    input  wire logic        oe_n,
    input  wire logic [3:0]  waits,
    output logic      [15:0] ad_i,
    output logic             rdy,
    output logic      [19:0] lat_addr,
    output logic      [15:0] wdat
);
    logic [3:0]  cnt_r  = 4'h0;
    logic [15:0] last_r = 16'h0;
    wire act = !oe_n && !(rd_n && wr_n);
    wire drv = act && !rd_n;
    always_ff @(posedge clk) begin
        if (ale && !ad_oe_n) lat_addr <= {up_o, ad_o};
        if (act && !wr_n && !ad_oe_n) wdat <= ad_o;
        cnt_r <= act ? cnt_r + 4'h1 : 4'h0;
        last_r <= ad_i;
    end
    // wire level: device, memory, else a changing pattern
    assign ad_i = !ad_oe_n ? ad_o : drv ? (lat_addr[15:0] ^ 16'h5A5A) : ~last_r;
    assign rdy = !act || cnt_r >= waits;
endmodule

//--- testbench/brms_checker_sva.sv
`timescale 1ns/10ps
module brms_checker (
    input wire logic       clk,
    input wire logic       sys_rst,
    input wire logic       req_valid,
    input wire logic       req_ready,
    input wire logic       rsp_valid,
    input wire logic       bus_hold_req,
    input wire logic       bus_grant_ack,
    input wire logic       processor_clock_out,
    input wire logic       muxed_addr_data_oe_n,
    input wire logic       upper_address_oe_n,
    input wire logic       byte_high_enable_n_oe_n,
    input wire logic [2:0] bus_cycle_status_o,
    input wire logic       bus_cycle_status_oe_n,
    input wire logic       read_strobe_n_o,
    input wire logic       write_strobe_n_o,
    input wire logic       transceiver_enable_n_o,
    input wire logic       strobes_oe_n,
    input wire logic       transceiver_direction_o,
    input wire logic       transceiver_direction_oe_n,
    input wire logic       bus_lock_o,
    input wire logic       bus_lock_oe_n,
    input wire logic       addr_latch_strobe,
    input wire logic       strap_pullup_en,
    input wire logic       queue_status_mode,
    input wire logic       extended_mode,
    input wire logic       power_save_en,
    input wire logic       refresh_en,
    input wire logic       coproc_if_en
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    // cycles since reset release, saturating
    logic [3:0] since_rst_r;
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            since_rst_r <= 4'h0;
        end else if (since_rst_r != 4'hF) begin
            since_rst_r <= since_rst_r + 4'h1;
        end
    end
    clk_half_a: assert property (
        since_rst_r >= 4'h3 |-> processor_clock_out != $past(processor_clock_out))
        else $error("processor clock not divided by two");
    rst_drive_a: assert property (
        $fell(sys_rst) |-> !strobes_oe_n && read_strobe_n_o && write_strobe_n_o
        && transceiver_enable_n_o && bus_cycle_status_o == 3'h7 && !bus_cycle_status_oe_n
        && bus_lock_o && !bus_lock_oe_n && !addr_latch_strobe && !bus_grant_ack)
        else $error("reset drive levels wrong");
    rst_float_a: assert property (
        $fell(sys_rst) |-> muxed_addr_data_oe_n && upper_address_oe_n
        && byte_high_enable_n_oe_n && transceiver_direction_oe_n && strap_pullup_en)
        else $error("pins not floated in reset");
    then_float_a: assert property (
        $fell(sys_rst) |-> ##[1:4] (strobes_oe_n && bus_cycle_status_oe_n && bus_lock_oe_n))
        else $error("reset drive not released");
    min_states_a: assert property (
        req_valid && req_ready |=> (!rsp_valid) [*7])
        else $error("bus cycle shorter than four states");
    rsp_bound_a: assert property (
        req_valid && req_ready |-> ##[8:200] rsp_valid)
        else $error("bus cycle never completed");
    hold_grant_a: assert property (
        bus_grant_ack |-> !req_ready && muxed_addr_data_oe_n && upper_address_oe_n)
        else $error("bus used while granted away");
    grant_cause_a: assert property (
        $rose(bus_grant_ack) |-> $past(bus_hold_req))
        else $error("grant without hold request");
    read_steer_a: assert property (
        !strobes_oe_n && !read_strobe_n_o |-> !transceiver_enable_n_o
        && !transceiver_direction_o && !transceiver_direction_oe_n)
        else $error("transceiver not set for read");
    write_steer_a: assert property (
        !strobes_oe_n && !write_strobe_n_o && !queue_status_mode
        |-> transceiver_direction_o && !muxed_addr_data_oe_n)
        else $error("write data not driven out");
    qs_reuse_a: assert property (
        queue_status_mode && !read_strobe_n_o |-> addr_latch_strobe && write_strobe_n_o)
        else $error("queue status pins not reused");
    mode_hold_a: assert property (
        since_rst_r >= 4'h6 |-> $stable({queue_status_mode, extended_mode}))
        else $error("mode changed after latch");
    ext_feat_a: assert property (
        $stable(extended_mode) |-> {power_save_en, refresh_en, coproc_if_en} == {3{extended_mode}})
        else $error("extended features do not follow mode");
    cover property (rsp_valid);
    cover property ($rose(bus_grant_ack));
    cover property ($fell(sys_rst) ##[1:8] extended_mode);
endmodule
bind brms_bus_ctrl brms_checker chk_i (.*);

//--- testbench/bus_reset_and_mode_straps_test.sv
`timescale 1ns/10ps
module bus_reset_and_mode_straps_test;
    import brms_pkg::*;
    logic clk = 1'b0, sys_rst = 1'b1, req_valid = 1'b0, req_write = 1'b0, bus_hold_req = 1'b0;
    logic [19:0] req_addr = 20'h0;
    logic [15:0] req_wdata = 16'h0;
    logic [3:0]  waits = 4'h0;
    logic rq = 1'b1, up_sel = 1'b1, lo_sel = 1'b1, tbz = 1'b1;
    wire  [15:0] ad_o, ad_i, rdata, wdat;
    wire  [19:0] lat;
    wire  [3:0]  up_o;
    wire ad_oe, ale, rd_n, wr_n, s_oe, rdy, rrdy, rvld, gnt, up_oe, st_oe, qm, pf, ext, ps, rf, cp;
    int n_fail = 0, cmp_count = 0, n;
    // strap row: rd, upper, lower, test in reset | queue, float, extended
    logic [6:0] rows [7] = '{7'h78, 7'h3C, 7'h4A, 7'h68, 7'h71, 7'h35, 7'h07};
    always #50 clk = ~clk;
    brms_bus_ctrl uut (.clk(clk), .sys_rst(sys_rst), .req_valid(req_valid),
        .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata), .req_ready(rrdy),
        .rsp_valid(rvld), .rsp_rdata(rdata), .sync_ready(rdy), .async_ready(1'b0),
        .bus_hold_req(bus_hold_req), .bus_grant_ack(gnt), .processor_clock_out(),
        .muxed_addr_data_o(ad_o), .muxed_addr_data_oe_n(ad_oe), .muxed_addr_data_i(ad_i),
        .upper_address_o(up_o), .upper_address_oe_n(up_oe), .byte_high_enable_n_o(),
        .byte_high_enable_n_oe_n(), .bus_cycle_status_o(), .bus_cycle_status_oe_n(st_oe),
        .read_strobe_n_o(rd_n), .write_strobe_n_o(wr_n), .transceiver_enable_n_o(),
        .strobes_oe_n(s_oe), .transceiver_direction_o(), .transceiver_direction_oe_n(),
        .bus_lock_o(), .bus_lock_oe_n(), .addr_latch_strobe(ale), .read_or_queue_strap(rq),
        .upper_mem_select(up_sel), .lower_mem_select(lo_sel), .test_busy(tbz), .strap_pullup_en(),
        .queue_status_mode(qm), .pin_float_test_mode(pf), .extended_mode(ext),
        .power_save_en(ps), .refresh_en(rf), .coproc_if_en(cp));
    brms_mem_model mem (.clk(clk), .ad_o(ad_o), .ad_oe_n(ad_oe), .up_o(up_o), .ale(ale),
        .rd_n(rd_n), .wr_n(wr_n), .oe_n(s_oe), .waits(waits), .ad_i(ad_i), .rdy(rdy),
        .lat_addr(lat), .wdat(wdat));
    task automatic chk(input string nm, input logic [19:0] s, input logic [19:0] e);
        cmp_count++;
        if (s !== e) begin
            n_fail++;
            $display("FAIL %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic give_verdict;
        $display("compares %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic do_reset(input logic [3:0] s);
        @(posedge clk);
        sys_rst <= 1'b1;
        {rq, up_sel, lo_sel, tbz} <= s;
        repeat (20) @(posedge clk);
        sys_rst <= 1'b0;
        tbz <= 1'b1;
        repeat (4) @(posedge clk);
        {rq, up_sel, lo_sel} <= 3'h7;
        repeat (8) @(posedge clk);
    endtask
    task automatic xfer(input logic w, input logic [19:0] a, input logic [15:0] d);
        @(posedge clk);
        {req_valid, req_write, req_addr, req_wdata} <= {1'b1, w, a, d};
        n = 0;
        do begin @(posedge clk); #1; n++; end while (rrdy !== 1'b1 && n < 60);
        @(posedge clk);
        req_valid <= 1'b0;
        n = 0;
        do begin @(posedge clk); #1; n++; end while (rvld !== 1'b1 && n < 200);
        chk("done", rvld, 1'b1);
        chk("address", lat, a);
    endtask
    initial begin
        for (int i = 0; i < 7; i++) begin
            do_reset(rows[i][6:3]);
            chk("modes", {qm, pf, ext}, rows[i][2:0]);
            chk("features", {ps, rf, cp}, {3{rows[i][0]}});
            if (rows[i][1]) chk("float", {s_oe, ad_oe, st_oe}, 3'h7);
        end
        do_reset(4'hF);
        xfer(1'b1, 20'hA1234, 16'hBEEF);
        chk("write data", wdat, 16'hBEEF);
        xfer(1'b0, 20'h5F00F, 16'h0);
        chk("read data", rdata, 16'hAA55);
        chk("min states", n >= 8, 1'b1);
        waits <= 4'h6;
        xfer(1'b0, 20'h0FFFF, 16'h0);
        chk("wait read", rdata, 16'hA5A5);
        chk("wait stretch", n > 8, 1'b1);
        @(posedge clk);
        bus_hold_req <= 1'b1;
        n = 0;
        do begin @(posedge clk); #1; n++; end while (gnt !== 1'b1 && n < 40);
        chk("grant", gnt, 1'b1);
        chk("granted", {rrdy, ad_oe, up_oe}, 3'h3);
        @(posedge clk);
        bus_hold_req <= 1'b0;
        repeat (10) @(posedge clk);
        chk("grant drop", gnt, 1'b0);
        do_reset(4'h7);
        chk("queue mode", qm, 1'b1);
        xfer(1'b0, 20'h5F00F, 16'h0);
        chk("queue read", rdata, 16'hAA55);
        give_verdict;
    end
    initial begin
        #(100 * 3000);
        n_fail++;
        give_verdict;
    end
endmodule
